// ==== pkg/event_sequencer_map.vh ====
// Purpose: Offsets, field positions, reset values and timing counts of the step sequencer
// Assumes: 100 MHz clock, byte offsets on an 8-bit register address
// Notes:   Definitions only
`ifndef EVENT_SEQUENCER_MAP_VH
`define EVENT_SEQUENCER_MAP_VH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS       10
`define HUNDREDTH_TIME_NS   10000000
`define HUNDREDTH_CYCLES    20'hf4240
`define PRESCALE_W          20

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFF_CTRL            8'h00
`define OFF_TIMEBASE        8'h04
`define OFF_PRESET_CFG      8'h08
`define OFF_PRESET_CTR      8'h0c
`define OFF_LAST_STEP       8'h10
`define OFF_STATUS          8'h14
`define OFF_IN_STEP_COUNT   8'h18
`define OFF_TICK_TIMER      8'h1c
`define OFF_CURRENT_STEP    8'h20
`define OFF_COUNTS_BASE     2'b01
`define OFF_EVENT_BASE      2'b10
`define OFF_PATTERN_BASE    2'b11

// ----------------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------------
`define CTRL_RETENTIVE_BIT  0
`define STATUS_DONE_BIT     0
`define EVENT_ENABLE_BIT    4

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_RETENTIVE       1'b1
`define RST_TIMEBASE        16'h0001
`define RST_STEP            5'h01
`define RST_LAST_STEP       5'h10

`endif

// ==== rtl/event_step_sequencer.v ====
// Purpose: Sixteen-step time/event sequencer driving a 16-bit output pattern
// Assumes: Control and event inputs come from outside logic and are synchronised here
// Notes:   State is evaluated once per controller scan pulse i_scan
`include "event_sequencer_map.vh"

module event_step_sequencer #(
  parameter [19:0] HUNDREDTH_CYCLES = `HUNDREDTH_CYCLES
) (
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_reset,
  // Controller scan and mode
  input  wire        i_scan,
  input  wire        i_run_mode,
  // Sequencer control contacts
  input  wire        i_start,
  input  wire        i_jog,
  input  wire        i_manual_reset_contact,
  // Event contacts
  input  wire [15:0] i_events,
  // Register port
  input  wire [7:0]  i_addr,
  input  wire [31:0] i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [31:0] o_rdata,
  // Sequencer outputs
  output reg  [15:0] o_step_out,
  output reg         o_completion_flag,
  output reg  [4:0]  o_current_step
);

  // --------------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------------
  reg  [19:0] meta_q;
  reg  [19:0] sync_q;
  wire        mode_s   = sync_q[0];
  wire        start_s  = sync_q[1];
  wire        jog_s    = sync_q[2];
  wire        rst_s    = sync_q[3];
  wire [15:0] events_s = sync_q[19:4];

  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      meta_q <= 20'h00000;
      sync_q <= 20'h00000;
    end else begin
      meta_q <= {i_events, i_manual_reset_contact, i_jog, i_start, i_run_mode};
      sync_q <= meta_q;
    end
  end

  // --------------------------------------------------------------------------
  // Hundredth-second timebase
  // --------------------------------------------------------------------------
  wire hund;

  seq_timebase #(
    .CYCLES (HUNDREDTH_CYCLES)
  ) u_timebase (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .o_tick  (hund)
  );

  // --------------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------------
  reg        retentive_q;
  reg [15:0] timebase_q;
  reg [4:0]  preset_cfg_q;
  reg [4:0]  last_step_q;
  reg [15:0] counts_q  [0:15];
  reg [4:0]  event_q   [0:15];
  reg [15:0] pattern_q [0:15];
  integer    i;

  wire       wr_cfg  = i_wr && (i_addr[7:6] == 2'b00);
  wire       wr_cnt  = i_wr && (i_addr[7:6] == `OFF_COUNTS_BASE);
  wire       wr_evt  = i_wr && (i_addr[7:6] == `OFF_EVENT_BASE);
  wire       wr_pat  = i_wr && (i_addr[7:6] == `OFF_PATTERN_BASE);
  wire [3:0] wr_idx  = i_addr[5:2];

  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      retentive_q  <= `RST_RETENTIVE;
      timebase_q   <= `RST_TIMEBASE;
      preset_cfg_q <= `RST_STEP;
      last_step_q  <= `RST_LAST_STEP;
      for (i = 0; i < 16; i = i + 1) begin
        counts_q[i]  <= 16'h0000;
        event_q[i]   <= 5'h00;
        pattern_q[i] <= 16'h0000;
      end
    end else begin
      if (wr_cfg && i_addr == `OFF_CTRL) begin
        retentive_q <= i_wdata[`CTRL_RETENTIVE_BIT];
      end
      if (wr_cfg && i_addr == `OFF_TIMEBASE) begin
        timebase_q <= i_wdata[15:0];
      end
      if (wr_cfg && i_addr == `OFF_PRESET_CFG) begin
        preset_cfg_q <= i_wdata[4:0];
      end
      if (wr_cfg && i_addr == `OFF_LAST_STEP) begin
        last_step_q <= i_wdata[4:0];
      end
      if (wr_cnt) begin
        counts_q[wr_idx] <= i_wdata[15:0];
      end
      if (wr_evt) begin
        event_q[wr_idx] <= i_wdata[4:0];
      end
      if (wr_pat) begin
        pattern_q[wr_idx] <= i_wdata[15:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Sequencer state
  // --------------------------------------------------------------------------
  reg [15:0] in_step_count_q;
  reg [15:0] in_step_count_d;
  reg [15:0] tick_timer_q;
  reg [15:0] tick_timer_d;
  reg [4:0]  preset_step_q;
  reg [4:0]  preset_step_d;
  reg [4:0]  current_step_q;
  reg [4:0]  current_step_d;
  reg        done_q;
  reg        done_d;
  reg        jog_prev_q;
  reg        mode_prev_q;
  reg        pend_q;
  reg        adv;

  wire [4:0]  cur_m1     = current_step_q - 5'h01;
  wire [3:0]  idx        = cur_m1[3:0];
  wire [15:0] step_cnt   = counts_q[idx];
  wire [4:0]  step_evt   = event_q[idx];
  // one selected event bit per step
  wire        ev_ok      = ~step_evt[`EVENT_ENABLE_BIT] | events_s[step_evt[3:0]];
  wire        running    = mode_s & start_s & ~rst_s & ~done_q;
  wire        tick_now   = pend_q | hund;
  wire        jog_edge   = jog_s & ~jog_prev_q;
  wire        mode_entry = mode_s & ~mode_prev_q;
  wire [15:0] tmr_inc    = tick_timer_q + 16'h0001;
  wire [15:0] isc_inc    = in_step_count_q + 16'h0001;

  always @* begin
    in_step_count_d = in_step_count_q;
    tick_timer_d    = tick_timer_q;
    preset_step_d   = preset_step_q;
    current_step_d  = current_step_q;
    done_d          = done_q;
    adv             = 1'b0;
    if (i_scan) begin
      if (mode_entry) begin
        done_d = 1'b0;
        if (!retentive_q) begin
          in_step_count_d = 16'h0000;
          tick_timer_d    = 16'h0000;
          preset_step_d   = preset_cfg_q;
          current_step_d  = preset_cfg_q;
        end
      end else if (rst_s) begin
        current_step_d  = preset_step_q;
        in_step_count_d = 16'h0000;
        tick_timer_d    = 16'h0000;
        done_d          = 1'b0;
      end else if (jog_edge && mode_s && !done_q) begin
        adv = 1'b1;
      end else if (running && ev_ok) begin
        if (step_cnt == 16'h0000) begin
          adv = 1'b1;
        end else if (tick_now) begin
          if (tmr_inc >= timebase_q) begin
            tick_timer_d = 16'h0000;
            if (isc_inc >= step_cnt) begin
              adv = 1'b1;
            end else begin
              in_step_count_d = isc_inc;
            end
          end else begin
            tick_timer_d = tmr_inc;
          end
        end
      end
      if (adv) begin
        in_step_count_d = 16'h0000;
        tick_timer_d    = 16'h0000;
        if (current_step_q == last_step_q) begin
          done_d = 1'b1;
        end else begin
          current_step_d = current_step_q + 5'h01;
        end
      end
    end
    if (wr_cfg && i_addr == `OFF_PRESET_CTR) begin
      preset_step_d = i_wdata[4:0];
    end
  end

  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      in_step_count_q <= 16'h0000;
      tick_timer_q    <= 16'h0000;
      preset_step_q   <= `RST_STEP;
      current_step_q  <= `RST_STEP;
      done_q          <= 1'b0;
      jog_prev_q      <= 1'b0;
      mode_prev_q     <= 1'b0;
      pend_q          <= 1'b0;
    end else begin
      in_step_count_q <= in_step_count_d;
      tick_timer_q    <= tick_timer_d;
      preset_step_q   <= preset_step_d;
      current_step_q  <= current_step_d;
      done_q          <= done_d;
      // Hundredth pulse held until a scan consumes it
      pend_q          <= i_scan ? 1'b0 : tick_now;
      if (i_scan) begin
        jog_prev_q  <= jog_s;
        mode_prev_q <= mode_s;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_step_out        <= 16'h0000;
      o_completion_flag <= 1'b0;
      o_current_step    <= `RST_STEP;
    end else begin
      // pattern shown whenever in run mode
      o_step_out        <= mode_s ? pattern_q[idx] : 16'h0000;
      o_completion_flag <= done_q;
      o_current_step    <= current_step_q;
    end
  end

  // --------------------------------------------------------------------------
  // Read port
  // --------------------------------------------------------------------------
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h00000000;
    case (i_addr[7:6])
      `OFF_COUNTS_BASE:  rd_mux = {16'h0000, counts_q[wr_idx]};
      `OFF_EVENT_BASE:   rd_mux = {27'h0000000, event_q[wr_idx]};
      `OFF_PATTERN_BASE: rd_mux = {16'h0000, pattern_q[wr_idx]};
      default: begin
        case (i_addr)
          `OFF_CTRL:          rd_mux = {31'h00000000, retentive_q};
          `OFF_TIMEBASE:      rd_mux = {16'h0000, timebase_q};
          `OFF_PRESET_CFG:    rd_mux = {27'h0000000, preset_cfg_q};
          `OFF_PRESET_CTR:    rd_mux = {27'h0000000, preset_step_q};
          `OFF_LAST_STEP:     rd_mux = {27'h0000000, last_step_q};
          `OFF_STATUS:        rd_mux = {31'h00000000, done_q};
          `OFF_IN_STEP_COUNT: rd_mux = {16'h0000, in_step_count_q};
          `OFF_TICK_TIMER:    rd_mux = {16'h0000, tick_timer_q};
          `OFF_CURRENT_STEP:  rd_mux = {27'h0000000, current_step_q};
          default:            rd_mux = 32'h00000000;
        endcase
      end
    endcase
  end

  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_rdata <= 32'h00000000;
    end else begin
      o_rdata <= i_rd ? rd_mux : 32'h00000000;
    end
  end

endmodule

// ==== rtl/seq_timebase.v ====
// Purpose: Free-running prescaler giving one pulse per hundredth of a second
// Assumes: Single clock domain
// Notes:   Period is a parameter so simulation can shorten it
module seq_timebase #(
  parameter [19:0] CYCLES = 20'd1000000
) (
  // Clock and reset
  input  wire i_clk,
  input  wire i_reset,
  // Tick
  output reg  o_tick
);

  reg [19:0] cnt_q;

  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt_q  <= 20'h00000;
      o_tick <= 1'b0;
    end else if (cnt_q >= CYCLES - 20'h00001) begin
      cnt_q  <= 20'h00000;
      o_tick <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 20'h00001;
      o_tick <= 1'b0;
    end
  end

endmodule

// ==== tb/seq_checker_asserts.sv ====
// Purpose: Port-level properties of the step sequencer
// Assumes: Scan pulses at most 3 cycles apart
// Notes:   Bound to the design from tb_top
`include "event_sequencer_map.vh"
module seq_checker (
  // Clock and reset
  input wire        i_clk,
  input wire        i_reset,
  // Watched inputs
  input wire        i_scan,
  input wire        i_run_mode,
  input wire        i_manual_reset_contact,
  input wire [7:0]  i_addr,
  input wire        i_rd,
  // Watched outputs
  input wire [31:0] o_rdata,
  input wire [15:0] o_step_out,
  input wire        o_completion_flag,
  input wire [4:0]  o_current_step
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside its slot");
  chk_unmapped_zero: assert property (i_rd && i_addr == 8'h24 |=> o_rdata == 32'h0)
    else $error("unmapped read not zero");
  chk_rd_current: assert property (i_rd && i_addr == `OFF_CURRENT_STEP && !i_scan |=>
    o_rdata == {27'h0, o_current_step}) else $error("current step read differs from pin");
  chk_prog_blank: assert property (!i_run_mode [*6] |-> o_step_out == 16'h0)
    else $error("outputs driven outside run mode");
  chk_scan_only: assert property (!$past(i_scan, 2) |-> $stable(o_current_step))
    else $error("step moved without a scan");
  chk_done_stable: assert property ($rose(o_completion_flag) |-> $stable(o_current_step))
    else $error("step moved on completion");
  chk_done_frozen: assert property (o_completion_flag && $past(o_completion_flag) |->
    $stable(o_current_step)) else $error("step moved while complete");
  chk_reset_hold: assert property (i_manual_reset_contact [*8] |->
    $stable(o_current_step) && !o_completion_flag) else $error("step moved during reset");

  cv_done: cover property ($rose(o_completion_flag));
  cv_reset: cover property (i_manual_reset_contact [*8]);
  cv_read: cover property (i_rd && i_addr == `OFF_CURRENT_STEP && !i_scan);
endmodule

// ==== tb/seq_ladder_model.sv ====
// Purpose: Ladder logic around the sequencer: scan pulse and reset rung
// Assumes: One scan every third clock
// Notes:   Auto restart ORs the completion flag into the reset rung
module seq_ladder (
  // Clock and reset
  input  wire  i_clk,
  input  wire  i_reset,
  // Ladder contacts
  input  wire  i_manual,
  input  wire  i_auto,
  input  wire  i_done,
  // Scan and reset rung
  output logic o_scan,
  output logic o_reset_contact
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] scan_cnt_q;

  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      scan_cnt_q <= 2'h0;
      o_scan <= 1'b0;
      o_reset_contact <= 1'b0;
    end else begin
      scan_cnt_q <= (scan_cnt_q == 2'h2) ? 2'h0 : scan_cnt_q + 2'h1;
      o_scan <= (scan_cnt_q == 2'h2);
      o_reset_contact <= i_manual | (i_auto & i_done);
    end
  end
endmodule

// ==== tb/tb_top.sv ====
// Purpose: Self-checking bench for the step sequencer
// Assumes: Prescaler shortened to 20 cycles per hundredth
// Notes:   Steps use counts 3 at timebase 2, except step 4, which has count 0 and waits on event bit 5
`include "event_sequencer_map.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst, run, start, jog, man, auto, scan, rcon, wr, rd, done;
  logic [15:0] ev, sout;
  logic [7:0]  addr;
  logic [31:0] wd, rdata;
  logic [4:0]  step;
  logic [39:0] rst_tab [8];
  int          err_count, num_checks, k;

  event_step_sequencer #(.HUNDREDTH_CYCLES(20'd20)) DUT (.i_clk(clk), .i_reset(rst), .i_scan(scan),
    .i_run_mode(run), .i_start(start), .i_jog(jog), .i_manual_reset_contact(rcon), .i_events(ev),
    .i_addr(addr), .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_step_out(sout),
    .o_completion_flag(done), .o_current_step(step));
  seq_ladder LADDER (.i_clk(clk), .i_reset(rst), .i_manual(man), .i_auto(auto), .i_done(done),
    .o_scan(scan), .o_reset_contact(rcon));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic print_verdict;
    if (err_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    cyc(1);
    wr <= 1'b0;
    cyc(1);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd <= 1'b1;
    addr <= a;
    cyc(1);
    rd <= 1'b0;
    #1 cmp(rdata, e);
    cyc(1);
  endtask
  task automatic wstep(input logic [4:0] e);
    int n;
    n = 0;
    while (step !== e && n < 300) begin
      cyc(1);
      n++;
    end
    cmp({27'h0, step}, {27'h0, e});
    if (n == 300) print_verdict;
  endtask
  task automatic jogp(input int n);
    repeat (n) begin
      jog <= 1'b1;
      cyc(8);
      jog <= 1'b0;
      cyc(8);
    end
  endtask

  initial begin
    {rst, run, start, jog, man, auto, wr, rd} = 8'h80;
    {ev, addr, wd} = '0;
    rst_tab = '{{`OFF_CTRL, 32'h1}, {`OFF_TIMEBASE, 32'h1}, {`OFF_PRESET_CFG, 32'h1}, {`OFF_PRESET_CTR, 32'h1},
      {`OFF_LAST_STEP, 32'h10}, {`OFF_CURRENT_STEP, 32'h1}, {`OFF_STATUS, 32'h0}, {8'h24, 32'h0}};
    cyc(6);
    rst <= 1'b0;
    cyc(1);
    foreach (rst_tab[i]) rchk(rst_tab[i][39:32], rst_tab[i][31:0]);
    for (k = 0; k < 16; k++) begin
      wreg(8'h40 + 8'(4 * k), (k == 3) ? 32'h0 : 32'h3);
      wreg(8'h80 + 8'(4 * k), (k == 3) ? 32'h15 : 32'h0);
      wreg(8'hc0 + 8'(4 * k), 32'h1 << k);
    end
    rchk(8'hfc, 32'h8000);
    wreg(`OFF_CTRL, 32'h0);
    wreg(`OFF_PRESET_CFG, 32'h3);
    wreg(`OFF_TIMEBASE, 32'h2);
    run <= 1'b1;
    cyc(12);
    cmp({27'h0, step}, 32'h3);
    cmp({16'h0, sout}, 32'h4);
    rchk(`OFF_PRESET_CTR, 32'h3);
    rchk(`OFF_IN_STEP_COUNT, 32'h0);
    jogp(1);
    cmp({27'h0, step}, 32'h4);
    start <= 1'b1;
    cyc(20);
    cmp({27'h0, step}, 32'h4);
    ev <= 16'h0020;
    wstep(5'h05);
    // At timebase 2 the step needs six hundredths; a timebase of 1 would leave by now
    cyc(70);
    cmp({27'h0, step}, 32'h5);
    wstep(5'h06);
    // Let one or two hundredths land so timer or count is non-zero before the jog
    cyc(30);
    start <= 1'b0;
    cyc(100);
    cmp({27'h0, step}, 32'h6);
    jogp(1);
    rchk(`OFF_TICK_TIMER, 32'h0);
    rchk(`OFF_IN_STEP_COUNT, 32'h0);
    start <= 1'b1;
    wstep(5'h08);
    man <= 1'b1;
    cyc(100);
    cmp({27'h0, step}, 32'h3);
    man <= 1'b0;
    start <= 1'b0;
    cyc(8);
    jogp(13);
    cmp({27'h0, step}, 32'h10);
    jogp(1);
    cmp({31'h0, done}, 32'h1);
    cmp({27'h0, step}, 32'h10);
    rchk(`OFF_STATUS, 32'h1);
    man <= 1'b1;
    cyc(10);
    man <= 1'b0;
    cyc(8);
    cmp({31'h0, done}, 32'h0);
    cmp({27'h0, step}, 32'h3);
    auto <= 1'b1;
    jogp(14);
    cyc(10);
    cmp({27'h0, step}, 32'h3);
    cmp({31'h0, done}, 32'h0);
    auto <= 1'b0;
    wreg(`OFF_CTRL, 32'h1);
    jogp(1);
    run <= 1'b0;
    cyc(10);
    cmp({16'h0, sout}, 32'h0);
    run <= 1'b1;
    cyc(12);
    cmp({27'h0, step}, 32'h4);
    rchk(`OFF_CURRENT_STEP, 32'h4);
    wreg(`OFF_CURRENT_STEP, 32'h9);
    rchk(`OFF_CURRENT_STEP, 32'h4);
    wreg(`OFF_PRESET_CTR, 32'h2);
    rchk(`OFF_PRESET_CTR, 32'h2);
    man <= 1'b1;
    cyc(10);
    man <= 1'b0;
    cyc(8);
    cmp({27'h0, step}, 32'h2);
    print_verdict;
  end
endmodule

bind event_step_sequencer seq_checker CHK (.i_clk(i_clk), .i_reset(i_reset), .i_scan(i_scan),
  .i_run_mode(i_run_mode), .i_manual_reset_contact(i_manual_reset_contact), .i_addr(i_addr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_step_out(o_step_out), .o_completion_flag(o_completion_flag),
  .o_current_step(o_current_step));
